// *** logic/afpd_core.sv ***
/*
 * serial frame engine of a sar converter with frame power-down control.
 * assumes cs_n, sclk and power_down_request come from the host pins,
 * and converted codes arrive from the analog core as a valid/ready stream.
 */
`timescale 1ns/1ps
`include "afpd_defs.svh"
// Behaviour
// - power-down request sampled only at cs rise
// - cs fall starts normal frame, samples
// - armed power-down entered at conversion end
// - data keeps shifting while powered down
// - wake on sclk rise, full after 1us
// - stay powered down while cs low
// - cs rise with request low exits
// - first bit at cs fall, rest on falls
// - cs low to 30th fall selects 32-clock
// - 32-clock mode sends 16 zeros first
module afpd_core
	import afpd_pkg::*;
#(
	parameter int RES        = 12,
	parameter int FIFO_DEPTH = 16,
	parameter int WAKE_CYC   = `AFPD_WAKE_CYCLES
) (
	input  wire logic        core_clk,
	input  wire logic        srst,
	input  wire logic        clk_en,
	input  wire logic        cs_n,
	input  wire logic        sclk,
	input  wire logic        power_down_request,
	output logic             sdo,
	output logic             sdo_oe_n,
	input  wire logic        code_valid,
	output logic             code_ready,
	input  wire logic [15:0] code_data,
	output logic             sample_strobe,
	output logic             convert_active,
	output logic             powered_down,
	output logic             fully_powered,
	output logic             mode32
);
	localparam logic [5:0] CONV_END = (RES == 8)  ? 6'(`AFPD_CONV_END_8)  :
	                                  (RES == 10) ? 6'(`AFPD_CONV_END_10) :
	                                                6'(`AFPD_CONV_END_12);
	localparam int WW = $clog2(WAKE_CYC + 1);

	// =============================================================
	// pin synchronisers
	// =============================================================
	logic [1:0] cs_sync;
	logic [1:0] sclk_sync;
	logic [1:0] pdr_sync;
	logic       cs_q;
	logic       sclk_q;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			cs_sync   <= 2'b11;
			sclk_sync <= 2'b00;
			pdr_sync  <= 2'b00;
			cs_q      <= 1'b1;
			sclk_q    <= 1'b0;
		end else if (clk_en) begin
			cs_sync   <= {cs_sync[0], cs_n};
			sclk_sync <= {sclk_sync[0], sclk};
			pdr_sync  <= {pdr_sync[0], power_down_request};
			cs_q      <= cs_sync[1];
			sclk_q    <= sclk_sync[1];
		end
	end

	logic cs_fall;
	logic cs_rise;
	logic sck_rise;
	logic sck_fall;
	logic cs_low;

	assign cs_low   = !cs_sync[1];
	assign cs_fall  = clk_en && cs_q && !cs_sync[1];
	assign cs_rise  = clk_en && !cs_q && cs_sync[1];
	assign sck_rise = clk_en && cs_low && !sclk_q && sclk_sync[1];
	assign sck_fall = clk_en && cs_low && sclk_q && !sclk_sync[1];

	// =============================================================
	// edge counters within a frame
	// =============================================================
	logic [5:0]  rise_cnt;
	logic [5:0]  fall_cnt;
	afpd_phase_t phase;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			rise_cnt <= '0;
			fall_cnt <= '0;
		end else if (cs_fall) begin
			rise_cnt <= '0;
			fall_cnt <= '0;
		end else begin
			if (sck_rise && rise_cnt != 6'h3f) begin
				rise_cnt <= rise_cnt + 6'h01;
			end
			if (sck_fall && fall_cnt != 6'h3f) begin
				fall_cnt <= fall_cnt + 6'h01;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			phase <= AFPD_IDLE;
		end else if (clk_en) begin
			case (phase)
				AFPD_IDLE: begin
					if (cs_fall) begin
						phase <= AFPD_CONVERT;
					end
				end
				AFPD_CONVERT: begin
					if (cs_rise) begin
						phase <= AFPD_IDLE;
					end else if (sck_rise && rise_cnt + 6'h01 == CONV_END) begin
						phase <= AFPD_SHIFT;
					end
				end
				AFPD_SHIFT: begin
					if (cs_rise) begin
						phase <= AFPD_IDLE;
					end
				end
				default: phase <= AFPD_IDLE;
			endcase
		end
	end

	assign convert_active = (phase == AFPD_CONVERT);
	assign sample_strobe  = cs_fall;

	// =============================================================
	// power-down control
	// =============================================================
	logic          pd_armed;
	logic [WW-1:0] wake_cnt;
	logic          waking;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			pd_armed <= 1'b0;
		end else if (cs_rise) begin
			pd_armed <= pdr_sync[1];
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			powered_down <= 1'b0;
		end else if (cs_rise && !pdr_sync[1]) begin
			powered_down <= 1'b0;
		end else if (phase == AFPD_CONVERT && sck_rise && rise_cnt + 6'h01 == CONV_END
			&& pd_armed) begin
			powered_down <= 1'b1;
		end
	end
	// no other path clears powered_down while cs stays low

	// wake starts on an sclk rise once the power-down is released
	always_ff @(posedge core_clk) begin
		if (srst) begin
			waking        <= 1'b0;
			wake_cnt      <= '0;
			fully_powered <= 1'b1;
		end else if (clk_en) begin
			if (powered_down) begin
				waking        <= 1'b0;
				fully_powered <= 1'b0;
			end else if (!fully_powered && !waking && sclk_q ^ sclk_sync[1] && sclk_sync[1]) begin
				waking   <= 1'b1;
				wake_cnt <= WW'(WAKE_CYC);
			end else if (waking) begin
				if (wake_cnt <= WW'(1)) begin
					waking        <= 1'b0;
					fully_powered <= 1'b1;
				end else begin
					wake_cnt <= wake_cnt - 1'b1;
				end
			end
		end
	end

	// =============================================================
	// frame mode and result stream
	// =============================================================
	always_ff @(posedge core_clk) begin
		if (srst) begin
			mode32 <= 1'b0;
		end else if (sck_fall && fall_cnt + 6'h01 == 6'(`AFPD_MODE32_FALL)) begin
			mode32 <= 1'b1;
		end else if (cs_rise && fall_cnt < 6'(`AFPD_MODE32_FALL)) begin
			mode32 <= 1'b0;
		end
	end

	logic        fifo_valid;
	logic        fifo_pop;
	logic [15:0] fifo_data;
	logic [15:0] last_code;

	afpd_fifo #(
		.WIDTH (16),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.core_clk  (core_clk),
		.srst      (srst),
		.clk_en    (clk_en),
		.in_valid  (code_valid),
		.in_ready  (code_ready),
		.in_data   (code_data),
		.out_valid (fifo_valid),
		.out_ready (fifo_pop),
		.out_data  (fifo_data)
	);

	// one result is taken at each frame start that finds the fifo non-empty
	assign fifo_pop = cs_fall && fifo_valid;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			last_code <= 16'h0000;
		end else if (fifo_pop) begin
			last_code <= fifo_data;
		end
	end

	// =============================================================
	// serial output
	// =============================================================
	logic [31:0] shreg;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			shreg    <= 32'h0000_0000;
			sdo      <= 1'b0;
			sdo_oe_n <= 1'b1;
		end else if (cs_rise) begin
			sdo_oe_n <= 1'b1;
			sdo      <= 1'b0;
		end else if (cs_fall) begin
			sdo_oe_n <= 1'b0;
			if (mode32) begin
				shreg <= {16'h0000, (fifo_valid ? fifo_data : last_code)};
				sdo   <= 1'b0;
			end else begin
				shreg <= {(fifo_valid ? fifo_data : last_code), 16'h0000};
				sdo   <= fifo_valid ? fifo_data[15] : last_code[15];
			end
		end else if (sck_fall && rise_cnt != 6'h00) begin
			shreg <= {shreg[30:0], 1'b0};
			sdo   <= shreg[30];
		end
	end
endmodule : afpd_core

// *** logic/afpd_defs.svh ***
/*
 * timing counts and frame positions for the frame power-down control block.
 * assumes inclusion by bare name from the package and the design modules.
 */
`ifndef AFPD_DEFS_SVH
`define AFPD_DEFS_SVH

// =============================================================
// core clock and wake-up timing
// =============================================================
`define AFPD_CLK_PERIOD_PS   5000
`define AFPD_WAKE_TIME_US    1
`define AFPD_WAKE_CYCLES     ((`AFPD_WAKE_TIME_US * 1000000 + `AFPD_CLK_PERIOD_PS - 1) / `AFPD_CLK_PERIOD_PS)

// =============================================================
// frame edge positions
// =============================================================
`define AFPD_MODE32_FALL     30
`define AFPD_ZERO_BITS       16
`define AFPD_FRAME16_BITS    16
`define AFPD_CONV_END_12     14
`define AFPD_CONV_END_10     11
`define AFPD_CONV_END_8      9

`endif

// *** logic/afpd_pkg.sv ***
/*
 * types shared by the frame power-down control block.
 * assumes the defs header is available on the include path.
 */
package afpd_pkg;
	`include "afpd_defs.svh"

	typedef enum logic [1:0] {
		AFPD_IDLE    = 2'b00,
		AFPD_CONVERT = 2'b01,
		AFPD_SHIFT   = 2'b10
	} afpd_phase_t;

	typedef struct packed {
		logic [15:0] word;
		logic        powered_down;
	} afpd_result_t;
endpackage : afpd_pkg

// *** logic/afpd_fifo.sv ***
/*
 * parameterised valid/ready fifo holding conversion results.
 * assumes one clock, synchronous active-high reset and a clock enable.
 */
`timescale 1ns/1ps
module afpd_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input  wire logic             core_clk,
	input  wire logic             srst,
	input  wire logic             clk_en,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic             push;
	logic             pop;

	assign in_ready  = (count != (AW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign push      = in_valid && in_ready && clk_en;
	assign pop       = out_valid && out_ready && clk_en;
	assign out_data  = mem[rd_ptr];

	always_ff @(posedge core_clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			end
			if (push && !pop) begin
				count <= count + 1'b1;
			end else if (pop && !push) begin
				count <= count - 1'b1;
			end
		end
	end
endmodule : afpd_fifo

// *** test/afpd_core_properties.sv ***
/*
 * concurrent checks on the frame power-down core ports.
 * assumes pins are synchronised inside, edges seen a few cycles late.
 */
`timescale 1ns/1ps
module afpd_core_properties (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic power_down_request,
	input wire logic sdo,
	input wire logic sdo_oe_n,
	input wire logic sample_strobe,
	input wire logic convert_active,
	input wire logic powered_down,
	input wire logic fully_powered,
	input wire logic mode32
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	// =============================================================
	// assertions and cover points
	// =============================================================
	chk_cs_fall_sample: assert property ($fell(cs_n) |-> ##[1:5] sample_strobe)
		else $error("no sample after cs fall");
	chk_strobe_pulse: assert property (sample_strobe |=> !sample_strobe)
		else $error("sample strobe too long");
	chk_oe_first_bit: assert property (sample_strobe |=> !sdo_oe_n)
		else $error("sdo not driven after sample");
	chk_sdo_on_fall: assert property ($changed(sdo) |-> !sclk)
		else $error("sdo changed with sclk high");
	chk_pd_hold_low: assert property (powered_down && !cs_n |=> powered_down)
		else $error("power-down left with cs low");
	chk_pd_exit_cs: assert property ($fell(powered_down) |-> cs_n)
		else $error("power-down left without cs high");
	chk_pd_exit_req: assert property ($rose(cs_n) && !power_down_request && powered_down
		|-> ##[2:7] !powered_down)
		else $error("power-down not left");
	chk_pd_conv_end: assert property ($rose(powered_down) |-> !cs_n ##1 !convert_active)
		else $error("power-down before conversion end");
	chk_wake_drop: assert property ($rose(powered_down) |-> ##[0:1] !fully_powered)
		else $error("fully powered in power-down");
	chk_mode32_zero: assert property (mode32 && sample_strobe |=> !sdo)
		else $error("mode32 first bit not zero");
	cover property (powered_down && !cs_n);
	cover property (mode32 && sample_strobe);
	cover property ($rose(fully_powered));
endmodule : afpd_core_properties

bind afpd_core afpd_core_properties u_chk (.core_clk(core_clk), .srst(srst), .cs_n(cs_n),
	.sclk(sclk), .power_down_request(power_down_request), .sdo(sdo), .sdo_oe_n(sdo_oe_n),
	.sample_strobe(sample_strobe), .convert_active(convert_active),
	.powered_down(powered_down), .fully_powered(fully_powered), .mode32(mode32));

// *** test/afpd_host.sv ***
/*
 * host model: frames on cs_n and sclk, power-down request, sdo capture.
 * assumes core_clk at 5 ns; sclk 125 ns, idle low outside frames.
 */
`timescale 1ns/1ps
module afpd_host (
	input  wire logic        core_clk,
	input  wire logic        sdo,
	output logic             cs_n,
	output logic             sclk,
	output logic             power_down_request,
	output int               rises,
	output logic [31:0]      rx
);
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		power_down_request = 1'b0;
		rises = 0;
		rx = 32'h0000_0000;
	end
	// n clocks; request mid frame, then pd before cs rise
	task automatic frame(input int n, input logic mid, input logic pd);
		rises <= 0;
		power_down_request <= mid;
		cs_n <= 1'b0;
		repeat (13) @(posedge core_clk);
		for (int i = 1; i <= n; i++) begin
			sclk <= 1'b1;
			rises <= i;
			repeat (12) @(posedge core_clk);
			rx <= {rx[30:0], sdo};
			sclk <= 1'b0;
			repeat (13) @(posedge core_clk);
		end
		power_down_request <= pd;
		repeat (4) @(posedge core_clk);
		cs_n <= 1'b1;
		repeat (240) @(posedge core_clk);
	endtask : frame
endmodule : afpd_host

// *** test/tb_top.sv ***
/*
 * self-checking bench for the frame power-down core with host model.
 * assumes one fifo word popped per frame and a wake count of 8.
 */
`timescale 1ns/1ps
module tb_top;
	logic        core_clk, srst, code_valid, code_ready, sdo, sdo_oe_n;
	logic        sample_strobe, convert_active, powered_down, fully_powered, mode32;
	logic        cs_n, sclk, power_down_request;
	logic        pd_res8;
	logic [15:0] code_data;
	logic [31:0] rx;
	int          rises, n_mismatch, samples_checked, cyc;
	afpd_core #(.WAKE_CYC(8)) uut (.core_clk(core_clk), .srst(srst), .clk_en(1'b1),
		.cs_n(cs_n), .sclk(sclk), .power_down_request(power_down_request), .sdo(sdo),
		.sdo_oe_n(sdo_oe_n), .code_valid(code_valid), .code_ready(code_ready),
		.code_data(code_data), .sample_strobe(sample_strobe),
		.convert_active(convert_active), .powered_down(powered_down),
		.fully_powered(fully_powered), .mode32(mode32));
	afpd_host u_host (.core_clk(core_clk), .sdo(sdo), .cs_n(cs_n), .sclk(sclk),
		.power_down_request(power_down_request), .rises(rises), .rx(rx));
	// 8-bit variant on the same pins, watched for its earlier conversion end
	afpd_core #(.RES(8), .WAKE_CYC(8)) uut_res8 (.core_clk(core_clk), .srst(srst),
		.clk_en(1'b1), .cs_n(cs_n), .sclk(sclk), .power_down_request(power_down_request),
		.sdo(), .sdo_oe_n(), .code_valid(code_valid), .code_ready(), .code_data(code_data),
		.sample_strobe(), .convert_active(), .powered_down(pd_res8), .fully_powered(),
		.mode32());
	// =============================================================
	// helpers
	// =============================================================
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	function automatic logic [15:0] word(input int k);
		return 16'(k * 16'h1111);
	endfunction : word
	task automatic at_rise(input int r, input int d);
		wait (rises == r);
		repeat (d) @(posedge core_clk);
		@(negedge core_clk);
	endtask : at_rise
	task automatic conclude;
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : conclude
	// =============================================================
	// scenarios
	// =============================================================
	task automatic t_fill;
		for (int i = 0; i < 16; i++) begin
			code_valid <= 1'b1;
			code_data <= word(i);
			@(posedge core_clk);
		end
		code_valid <= 1'b0;
		@(negedge core_clk);
		chk(32'(code_ready), 32'h0000_0000);
		@(posedge core_clk);
	endtask : t_fill
	task automatic t_powerdown;
		fork
			u_host.frame(16, 1'b1, 1'b0);
			begin
				at_rise(14, 8);
				chk(32'(powered_down), 32'h0000_0000);
			end
		join
		chk(32'(rx[15:0]), 32'(word(0)));
		chk(32'(code_ready), 32'h0000_0001);
		fork
			u_host.frame(16, 1'b0, 1'b1);
			begin
				at_rise(14, 8);
				chk(32'(powered_down), 32'h0000_0000);
			end
		join
		chk(32'(rx[15:0]), 32'(word(1)));
		fork
			u_host.frame(16, 1'b0, 1'b0);
			begin
				at_rise(9, 8);
				chk(32'(pd_res8), 32'h0000_0001);
				chk(32'(powered_down), 32'h0000_0000);
				at_rise(13, 20);
				chk(32'(powered_down), 32'h0000_0000);
				at_rise(14, 8);
				chk(32'(powered_down), 32'h0000_0001);
				chk(32'(fully_powered), 32'h0000_0000);
				at_rise(16, 8);
				chk(32'(powered_down), 32'h0000_0001);
			end
		join
		chk(32'(rx[15:0]), 32'(word(2)));
		chk(32'(powered_down), 32'h0000_0000);
		chk(32'(pd_res8), 32'h0000_0000);
	endtask : t_powerdown
	task automatic t_wake;
		fork
			u_host.frame(16, 1'b0, 1'b0);
			begin
				at_rise(1, 2);
				chk(32'(fully_powered), 32'h0000_0000);
				at_rise(2, 0);
				chk(32'(fully_powered), 32'h0000_0001);
			end
		join
		chk(32'(rx[15:0]), 32'(word(3)));
	endtask : t_wake
	task automatic t_mode32;
		u_host.frame(32, 1'b0, 1'b0);
		chk(32'(mode32), 32'h0000_0001);
		u_host.frame(32, 1'b0, 1'b1);
		chk(rx, {16'h0000, word(5)});
		fork
			u_host.frame(16, 1'b0, 1'b0);
			begin
				at_rise(15, 0);
				chk(32'(powered_down), 32'h0000_0001);
			end
		join
		chk(32'(mode32), 32'h0000_0000);
		chk(32'(powered_down), 32'h0000_0000);
	endtask : t_mode32
	// =============================================================
	// clock, reset, sequence, timeout
	// =============================================================
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	initial begin
		srst = 1'b1;
		code_valid = 1'b0;
		code_data = 16'h0000;
		repeat (12) @(posedge core_clk);
		srst <= 1'b0;
		@(posedge core_clk);
		t_fill();
		t_powerdown();
		t_wake();
		t_mode32();
		conclude();
	end
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 12000) begin
			n_mismatch++;
			conclude();
		end
	end
endmodule : tb_top
